// ==== rtl/fcd_pkg.sv ====
package fcd_pkg;
    // register byte offsets inside one channel window
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_SRC   = 5'h08;
    localparam logic [4:0] OFS_DST   = 5'h0c;
    localparam logic [4:0] OFS_NEXT  = 5'h10;
    // global registers
    localparam logic [7:0] OFS_STAT  = 8'h80;
    localparam logic [7:0] OFS_MASK  = 8'h84;
    localparam logic [7:0] OFS_BUSY  = 8'h88;
    // control fields
    localparam int CB_START = 0;
    localparam int CB_CHAIN = 1;
    localparam int CB_SHOLD = 2;
    localparam int CB_DHOLD = 3;
    localparam int CB_EXTEN = 4;
    localparam int CB_TMREN = 5;
    localparam int CB_GIVE  = 6;
    localparam int CB_SPORT = 8;
    localparam int CB_DPORT = 10;
    localparam int CTRL_W   = 12;
    localparam logic [11:0] CTRL_RST = 12'h000;
    // descriptor word 0: owner flag and byte count
    localparam int DB_OWN = 31;
    localparam int CNT_W  = 16;
    // staging buffer size in bytes, two of them
    localparam int FIFO_BYTES = 2048;
    localparam int LVL_W = 12;
    localparam logic [11:0] LVL_FULL = 12'h800;
    localparam int NCH = 4;
    localparam int NSLOT = 2;
    // slot sequencer
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_FETCH = 3'b001,
        S_READ  = 3'b010,
        S_WRITE = 3'b011,
        S_CLOSE = 3'b100
    } fcd_state_t;
endpackage : fcd_pkg

// ==== rtl/fcd_dma_top.sv ====
// Notes on behaviour
// - four channels, any port either side
// - two 2KB staging buffers, each lent to one active channel at a time
// - any byte alignment, realigned through buffer
// - source/destination increment or hold, independently
// - CPU may load parameters directly
// - chain loads next descriptor without CPU
// - start by write, request pin, timer
// - end-of-transfer input stops its channel
// - optionally return finished descriptor to CPU
// - written-back descriptor holds bytes left
`timescale 1ns/1ns
`default_nettype none
module fcd_dma_top import fcd_pkg::*; (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output var  logic [31:0]           avs_readdata_o,
    output var  logic                  avs_waitrequest_o,
    output var  logic                  irq_o,
    input  wire logic [3:0]            channel_transfer_request_n_i,
    input  wire logic [3:0]            timer_event_i,
    input  wire logic [3:0]            end_of_transfer_i,
    output var  logic [1:0]            mst_req_o,
    output var  logic [1:0]            mst_we_o,
    output var  logic [1:0][1:0]       mst_port_o,
    output var  logic [1:0][31:0]      mst_addr_o,
    output var  logic [1:0][31:0]      mst_wdata_o,
    output var  logic [1:0][3:0]       mst_be_o,
    input  wire logic [1:0]            mst_ack_i,
    input  wire logic [1:0][31:0]      mst_rdata_i
);
    // software copy of each channel
    logic [CTRL_W-1:0] ctl_q [NCH];
    logic [CNT_W-1:0]  cnt_q [NCH];
    logic [31:0]       src_q [NCH];
    logic [31:0]       dst_q [NCH];
    logic [31:0]       nxt_q [NCH];
    logic [7:0]        stat_q, stat_d;   // done [3:0], stop [7:4]
    logic [7:0]        mask_q;
    logic              irq_q;
    logic              wait_q, wait_d;   // high while idle
    logic [31:0]       rdat_q, rdat_d;
    logic [3:0]        pend_q, pend_d;   // triggered, no buffer yet
    // slot working set
    fcd_state_t        st_q [NSLOT], st_d [NSLOT];
    logic [1:0]        ch_q [NSLOT], ch_d [NSLOT];
    logic [CNT_W-1:0]  wc_q [NSLOT], wc_d [NSLOT];
    logic [31:0]       ws_q [NSLOT], ws_d [NSLOT];
    logic [31:0]       wd_q [NSLOT], wd_d [NSLOT];
    logic [31:0]       wn_q [NSLOT], wn_d [NSLOT];
    logic [31:0]       da_q [NSLOT], da_d [NSLOT];  // descriptor address
    logic [1:0]        fw_q [NSLOT], fw_d [NSLOT];  // fetch word index
    logic [LVL_W-1:0]  lv_q [NSLOT], lv_d [NSLOT];
    logic [LVL_W-1:0]  ix_q [NSLOT], ix_d [NSLOT];
    logic [1:0]        eot_q, eot_d;
    logic [1:0]        rq_q, rq_d, we_q, we_d;
    logic [1:0][1:0]   pt_q, pt_d;
    logic [1:0][31:0]  ad_q, ad_d, wdt_q, wdt_d;
    logic [1:0][3:0]   be_q, be_d;
    // staging buffers
    logic [7:0]        fifo_mem [NSLOT][FIFO_BYTES];
    logic [1:0]        fwe;
    logic [10:0]       fwa [NSLOT];
    logic [7:0]        fwd [NSLOT];
    // bus decode and events
    logic              acc, wr_go;
    logic [31:0]       bmask, trg;
    logic [3:0]        start, act, done_ev, stop_ev, take;
    logic [1:0]        gv;
    logic [1:0]        gch [NSLOT];
    logic [2:0]        ci;
    logic [1:0]        c;

    assign acc   = avs_read_i | avs_write_i;
    assign wr_go = avs_write_i & ~wait_q;
    assign ci    = avs_address_i[7:5];
    assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign trg   = avs_writedata_i;

    // software registers; writes land on the edge after waitrequest falls, where it rises again
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                ctl_q[i] <= CTRL_RST;
                cnt_q[i] <= '0;
                src_q[i] <= '0;
                dst_q[i] <= '0;
                nxt_q[i] <= '0;
            end
            mask_q <= '0;
        end else if (wr_go && !ci[2]) begin
            case (avs_address_i[4:0])
                OFS_CTRL:  ctl_q[ci[1:0]] <= CTRL_W'((ctl_q[ci[1:0]] & ~bmask[11:0])
                                          | (trg[11:0] & bmask[11:0] & 12'hffe));
                OFS_COUNT: cnt_q[ci[1:0]] <= (cnt_q[ci[1:0]] & ~bmask[15:0])
                                          | (trg[15:0] & bmask[15:0]);
                OFS_SRC:   src_q[ci[1:0]] <= (src_q[ci[1:0]] & ~bmask) | (trg & bmask);
                OFS_DST:   dst_q[ci[1:0]] <= (dst_q[ci[1:0]] & ~bmask) | (trg & bmask);
                OFS_NEXT:  nxt_q[ci[1:0]] <= (nxt_q[ci[1:0]] & ~bmask) | (trg & bmask);
                default:   ;
            endcase
        end else if (wr_go && avs_address_i == OFS_MASK && avs_byteenable_i[0]) begin
            mask_q <= trg[7:0];
        end
    end

    // start bit is a strobe and never stored
    always_comb begin
        start = '0;
        if (wr_go && !ci[2] && avs_address_i[4:0] == OFS_CTRL && avs_byteenable_i[0])
            start[ci[1:0]] = trg[CB_START];
    end

    // one wait state per access: taken at edge 1, answered at edge 2
    always_comb begin
        wait_d = 1'b1;
        rdat_d = rdat_q;
        if (acc && wait_q) begin
            wait_d = 1'b0;
            rdat_d = '0;            // unmapped reads as zero
            if (!ci[2]) begin
                case (avs_address_i[4:0])
                    OFS_CTRL:  rdat_d = {20'h0, ctl_q[ci[1:0]]};
                    OFS_COUNT: rdat_d = {16'h0, cnt_q[ci[1:0]]};
                    OFS_SRC:   rdat_d = src_q[ci[1:0]];
                    OFS_DST:   rdat_d = dst_q[ci[1:0]];
                    OFS_NEXT:  rdat_d = nxt_q[ci[1:0]];
                    default:   rdat_d = '0;
                endcase
            end else if (avs_address_i == OFS_STAT) begin
                rdat_d = {24'h0, stat_q};
            end else if (avs_address_i == OFS_MASK) begin
                rdat_d = {24'h0, mask_q};
            end else if (avs_address_i == OFS_BUSY) begin
                rdat_d = {24'h0, pend_q, act};
            end
        end
    end

    // channels currently holding a buffer
    always_comb begin
        act = '0;
        for (int s = 0; s < NSLOT; s++)
            if (st_q[s] != S_IDLE) act[ch_q[s]] = 1'b1;
    end

    // free slots take lowest pending channel, second slot the next
    always_comb begin
        take = '0;
        gv   = '0;
        for (int s = 0; s < NSLOT; s++) begin
            gch[s] = '0;
            for (int k = NCH - 1; k >= 0; k--) begin
                if (st_q[s] == S_IDLE && pend_q[k] && !take[k]) begin
                    gv[s]  = 1'b1;
                    gch[s] = 2'(k);
                end
            end
            if (gv[s]) take[gch[s]] = 1'b1;
        end
    end

    // three trigger sources feed the pending set
    always_comb begin
        pend_d = pend_q & ~take;
        for (int k = 0; k < NCH; k++) begin
            if (!act[k] && !take[k] && (start[k]
                || (ctl_q[k][CB_EXTEN] && !channel_transfer_request_n_i[k])
                || (ctl_q[k][CB_TMREN] && timer_event_i[k])))
                pend_d[k] = 1'b1;
        end
    end

    // slot sequencers
    always_comb begin
        done_ev = '0;
        stop_ev = '0;
        fwe     = '0;
        for (int s = 0; s < NSLOT; s++) begin
            st_d[s] = st_q[s];
            ch_d[s] = ch_q[s];
            wc_d[s] = wc_q[s];
            ws_d[s] = ws_q[s];
            wd_d[s] = wd_q[s];
            wn_d[s] = wn_q[s];
            da_d[s] = da_q[s];
            fw_d[s] = fw_q[s];
            lv_d[s] = lv_q[s];
            ix_d[s] = ix_q[s];
            fwa[s]  = lv_q[s][10:0];
            fwd[s]  = mst_rdata_i[s][8*ws_q[s][1:0] +: 8];
            c       = ch_q[s];
            eot_d[s] = eot_q[s];
            rq_d[s] = rq_q[s];
            we_d[s] = we_q[s];
            pt_d[s] = pt_q[s];
            ad_d[s] = ad_q[s];
            wdt_d[s] = wdt_q[s];
            be_d[s] = be_q[s];
            // latch end request for the served channel
            if (st_q[s] != S_IDLE && end_of_transfer_i[c]) eot_d[s] = 1'b1;
            if (rq_q[s] && mst_ack_i[s]) rq_d[s] = 1'b0;
            case (st_q[s])
                S_IDLE: if (gv[s]) begin
                    ch_d[s]  = gch[s];
                    eot_d[s] = 1'b0;
                    lv_d[s]  = '0;
                    ix_d[s]  = '0;
                    fw_d[s]  = '0;
                    if (ctl_q[gch[s]][CB_CHAIN]) begin
                        da_d[s] = nxt_q[gch[s]];
                        st_d[s] = S_FETCH;
                    end else begin
                        wc_d[s] = cnt_q[gch[s]];
                        ws_d[s] = src_q[gch[s]];
                        wd_d[s] = dst_q[gch[s]];
                        wn_d[s] = '0;
                        st_d[s] = S_READ;
                    end
                end
                S_FETCH: if (!rq_q[s]) begin
                    rq_d[s] = 1'b1;
                    we_d[s] = 1'b0;
                    pt_d[s] = ctl_q[c][CB_SPORT +: 2];
                    ad_d[s] = da_q[s] + {28'h0, fw_q[s], 2'b00};
                    be_d[s] = 4'hf;
                end else if (mst_ack_i[s]) begin
                    // descriptor words into the working set
                    fw_d[s] = fw_q[s] + 2'd1;
                    case (fw_q[s])
                        2'd0: begin
                            wc_d[s] = mst_rdata_i[s][CNT_W-1:0];
                            if (!mst_rdata_i[s][DB_OWN]) begin
                                stop_ev[c] = 1'b1;
                                st_d[s]    = S_IDLE;
                            end
                        end
                        2'd1: ws_d[s] = mst_rdata_i[s];
                        2'd2: wd_d[s] = mst_rdata_i[s];
                        default: begin
                            wn_d[s] = mst_rdata_i[s];
                            st_d[s] = S_READ;
                        end
                    endcase
                end
                S_READ: if (!rq_q[s]) begin
                    if (wc_q[s] == '0 || eot_q[s] || lv_q[s] == LVL_FULL) begin
                        st_d[s] = S_WRITE;
                    end else begin
                        // port select comes from the channel setup
                        rq_d[s] = 1'b1;
                        we_d[s] = 1'b0;
                        pt_d[s] = ctl_q[c][CB_SPORT +: 2];
                        ad_d[s] = ws_q[s];
                        be_d[s] = 4'hf;
                    end
                end else if (mst_ack_i[s]) begin
                    // one byte per beat from its source lane
                    fwe[s]  = 1'b1;
                    lv_d[s] = lv_q[s] + 12'd1;
                    wc_d[s] = wc_q[s] - 16'd1;
                    if (!ctl_q[c][CB_SHOLD]) ws_d[s] = ws_q[s] + 32'd1;
                end
                S_WRITE: if (!rq_q[s]) begin
                    if (ix_q[s] == lv_q[s]) begin
                        lv_d[s] = '0;
                        ix_d[s] = '0;
                        if (wc_q[s] != '0 && !eot_q[s]) begin
                            st_d[s] = S_READ;
                        end else if (ctl_q[c][CB_CHAIN] && ctl_q[c][CB_GIVE]) begin
                            st_d[s] = S_CLOSE;
                        end else if (ctl_q[c][CB_CHAIN] && wn_q[s] != '0 && !eot_q[s]) begin
                            da_d[s] = wn_q[s];
                            fw_d[s] = '0;
                            st_d[s] = S_FETCH;
                        end else begin
                            done_ev[c] = 1'b1;
                            st_d[s]    = S_IDLE;
                        end
                    end else begin
                        // byte lands in its destination lane
                        rq_d[s]  = 1'b1;
                        we_d[s]  = 1'b1;
                        pt_d[s]  = ctl_q[c][CB_DPORT +: 2];
                        ad_d[s]  = wd_q[s];
                        wdt_d[s] = {4{fifo_mem[s][ix_q[s][10:0]]}};
                        be_d[s]  = 4'h1 << wd_q[s][1:0];
                    end
                end else if (mst_ack_i[s]) begin
                    ix_d[s] = ix_q[s] + 12'd1;
                    if (!ctl_q[c][CB_DHOLD]) wd_d[s] = wd_q[s] + 32'd1;
                end
                S_CLOSE: if (!rq_q[s]) begin
                    rq_d[s]  = 1'b1;
                    we_d[s]  = 1'b1;
                    pt_d[s]  = ctl_q[c][CB_SPORT +: 2];
                    ad_d[s]  = da_q[s];
                    wdt_d[s] = {16'h0, wc_q[s]};
                    be_d[s]  = 4'hf;
                end else if (mst_ack_i[s]) begin
                    if (wn_q[s] != '0 && !eot_q[s]) begin
                        da_d[s] = wn_q[s];
                        fw_d[s] = '0;
                        st_d[s] = S_FETCH;
                    end else begin
                        done_ev[c] = 1'b1;
                        st_d[s]    = S_IDLE;
                    end
                end
                default: st_d[s] = S_IDLE;
            endcase
        end
    end

    // status: hardware set wins over write-one-to-clear
    always_comb begin
        stat_d = stat_q;
        if (wr_go && avs_address_i == OFS_STAT && avs_byteenable_i[0])
            stat_d = stat_q & ~trg[7:0];
        stat_d = stat_d | {stop_ev, done_ev};
    end

    // register stage for status, bus, master and slot state
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= '0;
            irq_q  <= 1'b0;
            wait_q <= 1'b1;
            rdat_q <= '0;
            pend_q <= '0;
            eot_q  <= '0;
            rq_q   <= '0;
            we_q   <= '0;
            pt_q   <= '0;
            ad_q   <= '0;
            wdt_q  <= '0;
            be_q   <= '0;
            for (int s = 0; s < NSLOT; s++) begin
                st_q[s] <= S_IDLE;
                ch_q[s] <= '0;
                wc_q[s] <= '0;
                ws_q[s] <= '0;
                wd_q[s] <= '0;
                wn_q[s] <= '0;
                da_q[s] <= '0;
                fw_q[s] <= '0;
                lv_q[s] <= '0;
                ix_q[s] <= '0;
            end
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
            wait_q <= wait_d;
            rdat_q <= rdat_d;
            pend_q <= pend_d;
            eot_q  <= eot_d;
            rq_q   <= rq_d;
            we_q   <= we_d;
            pt_q   <= pt_d;
            ad_q   <= ad_d;
            wdt_q  <= wdt_d;
            be_q   <= be_d;
            st_q   <= st_d;
            ch_q   <= ch_d;
            wc_q   <= wc_d;
            ws_q   <= ws_d;
            wd_q   <= wd_d;
            wn_q   <= wn_d;
            da_q   <= da_d;
            fw_q   <= fw_d;
            lv_q   <= lv_d;
            ix_q   <= ix_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        for (int s = 0; s < NSLOT; s++)
            if (fwe[s]) fifo_mem[s][fwa[s]] <= fwd[s];
    end

    assign avs_readdata_o    = rdat_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_o             = irq_q;
    assign mst_req_o         = rq_q;
    assign mst_we_o          = we_q;
    assign mst_port_o        = pt_q;
    assign mst_addr_o        = ad_q;
    assign mst_wdata_o       = wdt_q;
    assign mst_be_o          = be_q;

    // checks on slot 0 behaviour, slot sharing and the pending set
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_LVL_MAX: assert property (lv_q[0] <= LVL_FULL)
        else $error("buffer level past 2KB");
    AST_TWO_CH: assert property ((st_q[0] != S_IDLE && st_q[1] != S_IDLE)
        |-> ch_q[0] != ch_q[1])
        else $error("one channel in two slots");
    AST_SRC_STEP: assert property ((st_q[0] == S_READ && rq_q[0] && mst_ack_i[0])
        |=> ws_q[0] == $past(ws_q[0]) + (ctl_q[ch_q[0]][CB_SHOLD] ? 32'd0 : 32'd1))
        else $error("source step wrong");
    AST_DST_STEP: assert property ((st_q[0] == S_WRITE && rq_q[0] && mst_ack_i[0])
        |=> wd_q[0] == $past(wd_q[0]) + (ctl_q[ch_q[0]][CB_DHOLD] ? 32'd0 : 32'd1))
        else $error("destination step wrong");
    AST_OWN_STOP: assert property ((st_q[0] == S_FETCH && rq_q[0] && mst_ack_i[0]
        && fw_q[0] == 2'd0 && !mst_rdata_i[0][DB_OWN])
        |=> st_q[0] == S_IDLE && stat_q[4 + ch_q[0]])
        else $error("cpu owned descriptor not stopped");
    AST_EOT_STOP: assert property ((st_q[0] == S_READ && eot_q[0] && !rq_q[0])
        |=> st_q[0] == S_WRITE)
        else $error("end request ignored");
    AST_CLOSE_WB: assert property ((st_q[0] == S_CLOSE && rq_q[0])
        |-> we_q[0] && !wdt_q[0][DB_OWN] && wdt_q[0][15:0] == wc_q[0])
        else $error("close write-back wrong");
    AST_PEND_KEEP: assert property ((pend_q[2] && !take[2]) |=> pend_q[2])
        else $error("pending trigger lost");
    AST_REQ_HOLD: assert property ((rq_q[0] && !mst_ack_i[0])
        |=> rq_q[0] && $stable(ad_q[0]) && $stable(we_q[0]))
        else $error("master request dropped");
    AST_START_PEND: assert property ((start[1] && !act[1]) |=> pend_q[1] || act[1])
        else $error("start write lost");
    COV_CHAIN: cover property (st_q[0] == S_CLOSE ##[1:20] st_q[0] == S_FETCH);
    COV_BOTH: cover property (st_q[0] == S_READ && st_q[1] == S_READ);
    COV_WAIT3: cover property (&pend_q[2:0] && st_q[0] != S_IDLE && st_q[1] != S_IDLE);
endmodule : fcd_dma_top
`default_nettype wire

// ==== sim/fcd_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// far-side memory for both staging slots, one byte space per port
module fcd_mem_model (
    input  wire logic             mclk_i,
    input  wire logic [1:0]       req_i,
    input  wire logic [1:0]       we_i,
    input  wire logic [1:0][1:0]  port_i,
    input  wire logic [1:0][31:0] addr_i,
    input  wire logic [1:0][31:0] wdata_i,
    input  wire logic [1:0][3:0]  be_i,
    output var  logic [1:0]       ack_o,
    output var  logic [1:0][31:0] rdata_o
);
    logic [7:0]  mem [logic [33:0]]; // bytes keyed by port and address
    int          wt [2];             // idle cycles before the answer
    logic [33:0] k;                  // key of the byte in hand
    // untouched bytes read back a pattern of their own address
    function automatic logic [7:0] peek(input logic [33:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ {6'h0, a[33:32]};
    endfunction : peek
    // answer after 0..3 idle cycles; between answers the data lines keep moving
    // ack is unknown before the first edge, so only a solid one blocks a new answer
    always @(posedge mclk_i) begin
        for (int s = 0; s < 2; s++) begin
            ack_o[s] <= 1'b0;
            rdata_o[s] <= ~rdata_o[s];
            if (req_i[s] && ack_o[s] !== 1'b1) begin
                if (wt[s] > 0) begin
                    wt[s]--;
                end else begin
                    ack_o[s] <= 1'b1;
                    wt[s] = $urandom_range(3);
                    for (int b = 0; b < 4; b++) begin
                        k = {port_i[s], addr_i[s][31:2], 2'(b)};
                        if (we_i[s] && be_i[s][b]) mem[k] = wdata_i[s][8*b+:8];
                        rdata_o[s][8*b+:8] <= peek(k);
                    end
                end
            end
        end
    end
endmodule : fcd_mem_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench import fcd_pkg::*; ;
    logic             mclk, rst, rd, wr, wreq, irq; // clock, reset, register bus
    logic [7:0]       adr;
    logic [31:0]      wd, rdat, q;                  // q: last read word
    logic [3:0]       req_n, tmr, eot;              // channel trigger and end inputs
    logic [1:0]       mreq, mwe, mack;
    logic [1:0][1:0]  mport;
    logic [1:0][31:0] maddr, mwd, mrd;
    logic [1:0][3:0]  mbe;
    int               n_mismatch, checked, cyc;
    fcd_dma_top dut (.mclk_i(mclk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq),
        .channel_transfer_request_n_i(req_n), .timer_event_i(tmr), .end_of_transfer_i(eot),
        .mst_req_o(mreq), .mst_we_o(mwe), .mst_port_o(mport), .mst_addr_o(maddr),
        .mst_wdata_o(mwd), .mst_be_o(mbe), .mst_ack_i(mack), .mst_rdata_i(mrd));
    fcd_mem_model u_mem (.mclk_i(mclk), .req_i(mreq), .we_i(mwe), .port_i(mport),
        .addr_i(maddr), .wdata_i(mwd), .be_i(mbe), .ack_o(mack), .rdata_o(mrd));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // one register access; request held until waitrequest is seen low
    // no local limit: only the hang guard may end a wait for the answer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge mclk);
        end while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic prog(input int ch, input logic [11:0] c, input logic [15:0] cnt,
                        input logic [31:0] sa, input logic [31:0] da);
        logic [7:0] b;
        b = 8'(ch * 32);
        bus(1'b1, b + 8'(OFS_COUNT), {16'h0, cnt});
        bus(1'b1, b + 8'(OFS_SRC), sa);
        bus(1'b1, b + 8'(OFS_DST), da);
        bus(1'b1, b, {20'h0, c});
    endtask : prog
    // poll status for the given bits, check the line, then clear them
    task automatic wait_stat(input logic [31:0] m, input logic e);
        int n;
        n = 0;
        q = '0;
        while ((q & m) !== m && n < 300) begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end
        chk(q & m, m);
        chk({31'h0, irq}, {31'h0, e});
        bus(1'b1, OFS_STAT, m);
    endtask : wait_stat
    // expected bytes follow the channel's ports and hold choices
    task automatic verify(input logic [11:0] c, input int cnt, input logic [31:0] sa,
                          input logic [31:0] da);
        logic [33:0] ks, kd;
        for (int i = 0; i < cnt; i++) begin
            ks = {c[9:8], sa + (c[CB_SHOLD] ? 0 : i)};
            kd = {c[11:10], da + (c[CB_DHOLD] ? 0 : i)};
            if (!c[CB_DHOLD] || i == cnt - 1) chk(u_mem.peek(kd), u_mem.peek(ks));
        end
    endtask : verify
    task automatic pokew(input logic [31:0] a, input logic [31:0] d);
        for (int b = 0; b < 4; b++) u_mem.mem[{2'd1, a + 32'(b)}] = d[8*b+:8];
    endtask : pokew
    initial begin
        rst = 1'b1;
        {rd, wr, adr, wd, tmr, eot} = '0;
        req_n = '1;
        void'($urandom(32'hc58db7ae));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({30'h0, wreq, irq}, 32'h2);
        bus(1'b0, OFS_BUSY, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h9c, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 1024; i++) u_mem.mem[{2'd1, 32'h700 + 32'(i)}] = 8'($urandom);
        // sdram to pci, odd alignments, mask on so the line rises
        bus(1'b1, OFS_MASK, 32'h1);
        prog(0, 12'h101, 16'd5, 32'h701, 32'h203);
        wait_stat(32'h1, 1'b1);
        // the clear lands on the edge the write ends; the line falls on that same edge
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        verify(12'h101, 5, 32'h701, 32'h203);
        bus(1'b1, OFS_MASK, 32'h0);
        // device to cpu bus, source held, started by the timer
        prog(1, 12'he24, 16'd3, 32'h300, 32'h380);
        tmr[1] <= 1'b1;
        @(posedge mclk);
        tmr[1] <= 1'b0;
        wait_stat(32'h2, 1'b0);
        verify(12'he24, 3, 32'h300, 32'h380);
        // sdram to device, destination held, started by the request pin
        prog(3, 12'h918, 16'd4, 32'h710, 32'h840);
        req_n[3] <= 1'b0;
        q = '0;
        for (int n = 0; n < 60 && q[3] !== 1'b1; n++) bus(1'b0, OFS_BUSY, 32'h0);
        req_n[3] <= 1'b1;
        wait_stat(32'h8, 1'b0);
        verify(12'h918, 4, 32'h710, 32'h840);
        // chain: one owned descriptor, then a cpu-owned one stops it
        pokew(32'h400, 32'h8000_0004);
        pokew(32'h404, 32'h751);
        pokew(32'h408, 32'h602);
        pokew(32'h40c, 32'h410);
        pokew(32'h410, 32'h0);
        bus(1'b1, 8'h50, 32'h400);
        bus(1'b1, 8'h40, 32'h143);
        // a chain stopped by a cpu-owned descriptor reports stop only, not done
        wait_stat(32'h40, 1'b0);
        verify(12'h143, 4, 32'h751, 32'h602);
        // descriptors live on the source port, sdram here
        chk({u_mem.peek(34'h1_0000_0403), u_mem.peek(34'h1_0000_0402),
             u_mem.peek(34'h1_0000_0401), u_mem.peek(34'h1_0000_0400)}, 32'h0);
        // end-of-transfer cuts a long copy short
        prog(0, 12'h101, 16'd600, 32'h780, 32'h1000);
        repeat (30) @(posedge mclk);
        eot[0] <= 1'b1;
        repeat (2) @(posedge mclk);
        eot[0] <= 1'b0;
        wait_stat(32'h1, 1'b0);
        bus(1'b0, OFS_BUSY, 32'h0);
        chk(q, 32'h0);
        // three channels at once: the third waits for a free buffer
        prog(0, 12'h101, 16'd8, 32'h720, 32'h1400);
        prog(1, 12'h601, 16'd8, 32'h310, 32'h1500);
        prog(3, 12'hd01, 16'd8, 32'h730, 32'h1600);
        wait_stat(32'hb, 1'b0);
        verify(12'h101, 8, 32'h720, 32'h1400);
        verify(12'h601, 8, 32'h310, 32'h1500);
        verify(12'hd01, 8, 32'h730, 32'h1600);
        test_done();
    end
endmodule : testbench
`default_nettype wire
